// >>> hw/scdma_addr_step.sv
`timescale 1ns/100ps
`default_nettype none
module scdma_addr_step (
  input  wire logic [15:0]             addr,
  input  wire scdma_pkg::scdma_am_type am,
  input  wire logic [15:0]             elem_idx,
  input  wire logic [15:0]             frame_idx,
  input  wire logic                    last,
  output logic [15:0]                  nxt
);
  import scdma_pkg::*;

  // ==========================================================
  // Post-modification of one address
  always_comb
  begin
    unique case (am)
      AM_CONST: nxt = addr;
      AM_INC:   nxt = addr + 16'h0001;
      AM_DEC:   nxt = addr - 16'h0001;
      AM_INDEX: nxt = addr + (last ? frame_idx : elem_idx);
    endcase
  end

endmodule : scdma_addr_step
`default_nettype wire

// >>> hw/scdma_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module scdma_arbiter (
  input  wire logic [scdma_pkg::NUM_CH-1:0] req,
  input  wire logic [scdma_pkg::NUM_CH-1:0] high,
  input  wire logic [scdma_pkg::CH_W-1:0]   ptr_hi,
  input  wire logic [scdma_pkg::CH_W-1:0]   ptr_lo,
  output logic                              vld,
  output logic [scdma_pkg::CH_W-1:0]        idx
);
  import scdma_pkg::*;

  // ==========================================================
  // Level select, then rotate from the channel after the last grant
  always_comb
  begin
    logic [NUM_CH-1:0] pool;
    logic [CH_W-1:0]   ptr;
    logic              found;
    int                c;
    pool  = (|(req & high)) ? (req & high) : (req & ~high);
    ptr   = (|(req & high)) ? ptr_hi : ptr_lo;
    found = 1'b0;
    idx   = '0;
    c     = 0;
    for (int k = 1; k <= NUM_CH; k++)
    begin
      c = int'(ptr) + k;
      if (c >= NUM_CH)
        c = c - NUM_CH;
      if (!found && pool[c])
      begin
        found = 1'b1;
        idx   = CH_W'(c);
      end
    end
    vld = found;
  end

endmodule : scdma_arbiter
`default_nettype wire

// >>> hw/scdma_pkg.sv
`default_nettype none
package scdma_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH  = 6;
  localparam int CH_W    = 3;
  localparam int NUM_EVT = 16;

  // ==========================================================
  // Word indices (byte address = 4 * index)
  localparam logic [7:0] IDX_SRC_PAGE = 8'h28;
  localparam logic [7:0] IDX_DST_PAGE = 8'h29;
  localparam logic [7:0] IDX_GSRC     = 8'h30;
  localparam logic [7:0] IDX_GDST     = 8'h31;
  localparam logic [7:0] IDX_GCNT     = 8'h32;
  localparam logic [7:0] IDX_GFRM     = 8'h33;
  localparam logic [7:0] IDX_EIDX     = 8'h34;
  localparam logic [7:0] IDX_FIDX     = 8'h35;
  localparam logic [7:0] IDX_PRIO     = 8'h36;
  localparam logic [7:0] IDX_EXTSEL   = 8'h37;
  localparam logic [7:0] IDX_STAT     = 8'h38;
  localparam logic [1:0] CH_AREA      = 2'b01;

  // Slots inside a channel block of eight words
  localparam logic [2:0] SLOT_SRC  = 3'h0;
  localparam logic [2:0] SLOT_DST  = 3'h1;
  localparam logic [2:0] SLOT_ECNT = 3'h2;
  localparam logic [2:0] SLOT_FCNT = 3'h3;
  localparam logic [2:0] SLOT_MODE = 3'h4;
  localparam logic [2:0] SLOT_SYNC = 3'h5;

  // ==========================================================
  // Channel mode control fields
  localparam int MODE_DWORD  = 0;
  localparam int MODE_AUTO   = 1;
  localparam int MODE_DAM    = 2;
  localparam int MODE_FIRQ   = 4;
  localparam int MODE_DEXT   = 5;
  localparam int MODE_SAM    = 8;
  localparam int MODE_SEXT   = 11;
  localparam int MODE_IEN    = 12;
  localparam int MODE_EN     = 15;
  localparam int EXT_RD_LSB  = 0;
  localparam int EXT_WR_LSB  = 4;

  // ==========================================================
  // Reset values and constants
  localparam logic [15:0] EXTSEL_RST  = 16'h0010;
  localparam logic [15:0] PERIPH_TOP  = 16'h0060;
  localparam logic [3:0]  SYNC_FREE   = 4'h0;
  localparam logic [1:0]  HTRANS_NSEQ = 2'b10;
  localparam logic [2:0]  HSIZE_WORD  = 3'b010;
  localparam logic        HRESP_OKAY  = 1'b0;

  typedef enum logic [1:0] {
    AM_CONST = 2'b00,
    AM_INC   = 2'b01,
    AM_DEC   = 2'b10,
    AM_INDEX = 2'b11
  } scdma_am_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } scdma_state_type;

  function automatic logic scdma_is_periph(input logic [15:0] a);
    return a < PERIPH_TOP;
  endfunction : scdma_is_periph

endpackage : scdma_pkg
`default_nettype wire

// >>> hw/scdma_top.sv
// Functional notes
// - Six independent channel contexts run in background
// - Controller wins over CPU on contention
// - High/low priority; round-robin within a level
// - Source/destination constant, inc, dec or indexed
// - Event sync start only for internal transfers
// - Each channel raises its own interrupt
// - Double-word: element is two 16-bit accesses
// - One external-read channel, one external-write channel
// - External accesses are single-word only
// - No peripheral to external transfers, either way
// - Mode bit 5 selects off-chip destination
// - Mode bit 11 selects off-chip source
// - Fixed map, CPU map bits ignored
// - Autoinit reloads source, destination, count after block
// - Retained reload values reused every block
// - Element count per element (both halves read in double-word), frame count per frame
// - Sync select zero means free running
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module scdma_top (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  output logic                              mem_req,
  output logic                              mem_we,
  output logic                              mem_ext,
  output logic [22:0]                       mem_addr,
  output logic [15:0]                       mem_wdata,
  input  wire logic [15:0]                  mem_rdata,
  input  wire logic                         mem_ack,
  input  wire logic [scdma_pkg::NUM_EVT-1:0] sync_evt,
  input  wire logic                         cpu_req,
  output logic                              cpu_gnt,
  output logic [scdma_pkg::NUM_CH-1:0]      chan_irq
);
  import scdma_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_CH-1:0][15:0] src;
    logic [NUM_CH-1:0][15:0] dst;
    logic [NUM_CH-1:0][15:0] ecnt;
    logic [NUM_CH-1:0][15:0] einit;
    logic [NUM_CH-1:0][15:0] mode;
    logic [NUM_CH-1:0][7:0]  fcnt;
    logic [NUM_CH-1:0][3:0]  sync;
    logic [NUM_CH-1:0]       pend;
    logic [15:0]             gsrc;
    logic [15:0]             gdst;
    logic [15:0]             gcnt;
    logic [7:0]              gfrm;
    logic [15:0]             eidx;
    logic [15:0]             fidx;
    logic [NUM_CH-1:0]       prio;
    logic [15:0]             extsel;
    logic [6:0]              spage;
    logic [6:0]              dpage;
    scdma_state_type         state;
    logic [CH_W-1:0]         cur;
    logic [CH_W-1:0]         rr_hi;
    logic [CH_W-1:0]         rr_lo;
    logic                    half;
    logic                    lastx;
    logic                    blk_end;
    logic                    a_valid;
    logic                    a_write;
    logic [7:0]              a_idx;
    logic [31:0]             hrdata;
    logic                    hready;
    logic                    hresp;
    logic                    mem_req;
    logic                    mem_we;
    logic                    mem_ext;
    logic [22:0]             mem_addr;
    logic [15:0]             mem_wdata;
    logic [NUM_CH-1:0]       irq;
    logic                    cpu_gnt;
  } scdma_regs_type;

  scdma_regs_type    s_ff;
  scdma_regs_type    nxt_s;
  logic [NUM_CH-1:0] elig;
  logic              grant_vld;
  logic [CH_W-1:0]   grant_idx;
  logic [15:0]       cur_mode;
  logic              cur_off;
  logic              cur_dw;
  logic              elem_done;
  logic              src_last;
  logic [15:0]       src_nxt;
  logic [15:0]       dst_nxt;

  // ==========================================================
  // Eligibility of one channel
  function automatic logic chan_ready(
    input logic [15:0]     mode,
    input logic [3:0]      sync,
    input logic            pend,
    input logic [15:0]     src,
    input logic [15:0]     dst,
    input logic [CH_W-1:0] ch,
    input logic [15:0]     extsel
  );
    logic sx;
    logic dx;
    logic ok_ext;
    logic no_pe;
    logic free;
    sx     = mode[MODE_SEXT];
    dx     = mode[MODE_DEXT];
    ok_ext = (!sx || extsel[EXT_RD_LSB +: CH_W] == ch) &&
             (!dx || extsel[EXT_WR_LSB +: CH_W] == ch);
    no_pe  = !(sx && !dx && scdma_is_periph(dst)) &&
             !(dx && !sx && scdma_is_periph(src));
    // Off-chip work ignores events, so it always runs free
    free   = (sync == SYNC_FREE) || sx || dx;
    return mode[MODE_EN] && ok_ext && no_pe && (free || pend);
  endfunction : chan_ready

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_elig
    assign elig[g] = chan_ready(s_ff.mode[g], s_ff.sync[g],
                                s_ff.pend[g], s_ff.src[g],
                                s_ff.dst[g], CH_W'(g),
                                s_ff.extsel);
  end

  scdma_arbiter u_arb (
    .req    (elig),
    .high   (s_ff.prio),
    .ptr_hi (s_ff.rr_hi),
    .ptr_lo (s_ff.rr_lo),
    .vld    (grant_vld),
    .idx    (grant_idx)
  );

  assign cur_mode  = s_ff.mode[s_ff.cur];
  assign cur_off   = cur_mode[MODE_SEXT] | cur_mode[MODE_DEXT];
  assign cur_dw    = cur_mode[MODE_DWORD] & ~cur_off;
  assign elem_done = ~cur_dw | s_ff.half;
  assign src_last  = elem_done && (s_ff.ecnt[s_ff.cur] == 16'h0000);

  scdma_addr_step u_src_step (
    .addr      (s_ff.src[s_ff.cur]),
    .am        (scdma_am_type'(cur_mode[MODE_SAM +: 2])),
    .elem_idx  (s_ff.eidx),
    .frame_idx (s_ff.fidx),
    .last      (src_last),
    .nxt       (src_nxt)
  );

  scdma_addr_step u_dst_step (
    .addr      (s_ff.dst[s_ff.cur]),
    .am        (scdma_am_type'(cur_mode[MODE_DAM +: 2])),
    .elem_idx  (s_ff.eidx),
    .frame_idx (s_ff.fidx),
    .last      (s_ff.lastx),
    .nxt       (dst_nxt)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [CH_W-1:0] ch;
    logic [15:0]     rd;
    logic            ch_hit;
    ch     = s_ff.a_idx[5:3];
    rd     = 16'h0000;
    ch_hit = (s_ff.a_idx[7:6] == CH_AREA) && (int'(ch) < NUM_CH);
    nxt_s  = s_ff;
    nxt_s.irq     = '0;
    nxt_s.cpu_gnt = 1'b0;

    unique case (s_ff.state)
      ST_IDLE:
      begin
        // The CPU only gets the port when no channel wants it
        nxt_s.cpu_gnt = cpu_req & ~grant_vld;
        if (grant_vld)
        begin
          nxt_s.cur  = grant_idx;
          if (s_ff.prio[grant_idx])
            nxt_s.rr_hi = grant_idx;
          else
            nxt_s.rr_lo = grant_idx;
          nxt_s.pend[grant_idx] = 1'b0;
          nxt_s.half     = 1'b0;
          nxt_s.mem_req  = 1'b1;
          nxt_s.mem_we   = 1'b0;
          nxt_s.mem_ext  = s_ff.mode[grant_idx][MODE_SEXT];
          // Address is page plus offset only: no CPU map bits
          nxt_s.mem_addr = {s_ff.spage, s_ff.src[grant_idx]};
          nxt_s.state    = ST_READ;
        end
      end
      ST_READ:
      begin
        if (mem_ack)
        begin
          nxt_s.mem_wdata      = mem_rdata;
          nxt_s.src[s_ff.cur]  = src_nxt;
          nxt_s.mem_we         = 1'b1;
          nxt_s.mem_ext        = cur_mode[MODE_DEXT];
          nxt_s.mem_addr       = {s_ff.dpage, s_ff.dst[s_ff.cur]};
          nxt_s.lastx          = src_last;
          nxt_s.state          = ST_WRITE;
          if (elem_done)
          begin
            if (s_ff.ecnt[s_ff.cur] != 16'h0000)
              nxt_s.ecnt[s_ff.cur] = s_ff.ecnt[s_ff.cur] - 16'h0001;
            else if (s_ff.fcnt[s_ff.cur] != 8'h00)
            begin
              nxt_s.fcnt[s_ff.cur] = s_ff.fcnt[s_ff.cur] - 8'h01;
              nxt_s.ecnt[s_ff.cur] = s_ff.einit[s_ff.cur];
              nxt_s.irq[s_ff.cur]  = cur_mode[MODE_IEN] &
                                     cur_mode[MODE_FIRQ];
            end
            else
              nxt_s.blk_end = 1'b1;
          end
        end
      end
      ST_WRITE:
      begin
        if (mem_ack)
        begin
          nxt_s.dst[s_ff.cur] = dst_nxt;
          nxt_s.mem_we        = 1'b0;
          if (cur_dw && !s_ff.half)
          begin
            nxt_s.half     = 1'b1;
            nxt_s.mem_ext  = cur_mode[MODE_SEXT];
            nxt_s.mem_addr = {s_ff.spage, s_ff.src[s_ff.cur]};
            nxt_s.state    = ST_READ;
          end
          else
          begin
            nxt_s.mem_req = 1'b0;
            nxt_s.half    = 1'b0;
            nxt_s.lastx   = 1'b0;
            nxt_s.state   = ST_IDLE;
            if (s_ff.blk_end)
            begin
              nxt_s.blk_end       = 1'b0;
              nxt_s.irq[s_ff.cur] = cur_mode[MODE_IEN];
              if (cur_mode[MODE_AUTO])
              begin
                // Reload registers are only read here, never cleared
                nxt_s.src[s_ff.cur]   = s_ff.gsrc;
                nxt_s.dst[s_ff.cur]   = s_ff.gdst;
                nxt_s.ecnt[s_ff.cur]  = s_ff.gcnt;
                nxt_s.einit[s_ff.cur] = s_ff.gcnt;
                nxt_s.fcnt[s_ff.cur]  = s_ff.gfrm;
              end
              else
                nxt_s.mode[s_ff.cur][MODE_EN] = 1'b0;
            end
          end
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase

    // Event capture after the grant clear, so a new event wins
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (s_ff.sync[c] != SYNC_FREE && sync_evt[s_ff.sync[c]])
        nxt_s.pend[c] = 1'b1;
    end

    // Register write in the data phase; software wins over hardware
    if (s_ff.a_valid && s_ff.a_write && s_ff.hready)
    begin
      if (ch_hit)
      begin
        unique case (s_ff.a_idx[2:0])
          SLOT_SRC:  nxt_s.src[ch] = hwdata[15:0];
          SLOT_DST:  nxt_s.dst[ch] = hwdata[15:0];
          SLOT_ECNT:
          begin
            nxt_s.ecnt[ch]  = hwdata[15:0];
            nxt_s.einit[ch] = hwdata[15:0];
          end
          SLOT_FCNT: nxt_s.fcnt[ch] = hwdata[7:0];
          SLOT_MODE: nxt_s.mode[ch] = hwdata[15:0];
          SLOT_SYNC: nxt_s.sync[ch] = hwdata[3:0];
          default: ;
        endcase
      end
      else
      begin
        // Reload writes take effect at the next block end only
        unique case (s_ff.a_idx)
          IDX_SRC_PAGE: nxt_s.spage  = hwdata[6:0];
          IDX_DST_PAGE: nxt_s.dpage  = hwdata[6:0];
          IDX_GSRC:     nxt_s.gsrc   = hwdata[15:0];
          IDX_GDST:     nxt_s.gdst   = hwdata[15:0];
          IDX_GCNT:     nxt_s.gcnt   = hwdata[15:0];
          IDX_GFRM:     nxt_s.gfrm   = hwdata[7:0];
          IDX_EIDX:     nxt_s.eidx   = hwdata[15:0];
          IDX_FIDX:     nxt_s.fidx   = hwdata[15:0];
          IDX_PRIO:     nxt_s.prio   = hwdata[NUM_CH-1:0];
          IDX_EXTSEL:   nxt_s.extsel = hwdata[15:0];
          default: ;
        endcase
      end
    end

    // Read data phase: one wait state so hrdata comes from a flop
    if (s_ff.a_valid && !s_ff.a_write && !s_ff.hready)
    begin
      if (ch_hit)
      begin
        unique case (s_ff.a_idx[2:0])
          SLOT_SRC:  rd = s_ff.src[ch];
          SLOT_DST:  rd = s_ff.dst[ch];
          SLOT_ECNT: rd = s_ff.ecnt[ch];
          SLOT_FCNT: rd = {8'h00, s_ff.fcnt[ch]};
          SLOT_MODE: rd = s_ff.mode[ch];
          SLOT_SYNC: rd = {12'h000, s_ff.sync[ch]};
          default:   rd = 16'h0000;
        endcase
      end
      else
      begin
        unique case (s_ff.a_idx)
          IDX_SRC_PAGE: rd = {9'h000, s_ff.spage};
          IDX_DST_PAGE: rd = {9'h000, s_ff.dpage};
          IDX_GSRC:     rd = s_ff.gsrc;
          IDX_GDST:     rd = s_ff.gdst;
          IDX_GCNT:     rd = s_ff.gcnt;
          IDX_GFRM:     rd = {8'h00, s_ff.gfrm};
          IDX_EIDX:     rd = s_ff.eidx;
          IDX_FIDX:     rd = s_ff.fidx;
          IDX_PRIO:     rd = {10'h000, s_ff.prio};
          IDX_EXTSEL:   rd = s_ff.extsel;
          IDX_STAT:     rd = {2'h0, s_ff.pend, 1'b0, s_ff.cur,
                              s_ff.half, 1'b0, s_ff.state};
          default:      rd = 16'h0000;
        endcase
      end
      nxt_s.hrdata  = {16'h0000, rd};
      nxt_s.hready  = 1'b1;
      nxt_s.a_valid = 1'b0;
    end

    // Address phase
    if (hready)
    begin
      nxt_s.a_valid = hsel && (htrans == HTRANS_NSEQ) &&
                      (hsize == HSIZE_WORD);
      nxt_s.a_write = hwrite;
      nxt_s.a_idx   = haddr[9:2];
      if (hsel && (htrans == HTRANS_NSEQ) && (hsize == HSIZE_WORD) &&
          !hwrite)
        nxt_s.hready = 1'b0;
    end
    nxt_s.hresp = HRESP_OKAY;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_ff        <= '0;
      s_ff.hready <= 1'b1;
      s_ff.extsel <= EXTSEL_RST;
    end
    else
      s_ff <= nxt_s;
  end

  assign hreadyout = s_ff.hready;
  assign hresp     = s_ff.hresp;
  assign hrdata    = s_ff.hrdata;
  assign mem_req   = s_ff.mem_req;
  assign mem_we    = s_ff.mem_we;
  assign mem_ext   = s_ff.mem_ext;
  assign mem_addr  = s_ff.mem_addr;
  assign mem_wdata = s_ff.mem_wdata;
  assign cpu_gnt   = s_ff.cpu_gnt;
  assign chan_irq  = s_ff.irq;

endmodule : scdma_top
`default_nettype wire

// >>> testbench/scdma_mem.sv
`timescale 1ns/100ps
`default_nettype none
// =========================================
// Memory side model, latency set by lat
module scdma_mem (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_ext,
  input  wire logic [22:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [3:0]  lat,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  logic [3:0]  cnt;
  logic [15:0] last;
  logic [22:0] wa[$];
  logic [15:0] wd[$];
  logic        wx[$];
  logic        rx[$];
  // Outside an ack the data shows the inverse, so a stale sample is caught
  assign mem_rdata = mem_ack ? last : ~last;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt     <= 4'h0;
      mem_ack <= 1'b0;
      last    <= 16'h0;
    end
    else if (mem_ack || !mem_req)
    begin
      mem_ack <= 1'b0;
      cnt     <= 4'h0;
    end
    else if (cnt < lat)
      cnt <= cnt + 4'h1;
    else
    begin
      mem_ack <= 1'b1;
      if (mem_we)
      begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
        wx.push_back(mem_ext);
      end
      else
      begin
        last <= mem_addr[15:0] ^ 16'h5000 ^ {mem_addr[22:16], 9'h000};
        rx.push_back(mem_ext);
      end
    end
endmodule : scdma_mem
`default_nettype wire

// >>> testbench/scdma_sva.sv
`timescale 1ns/100ps
`default_nettype none
// =========================================
// Port checks
module scdma_sva
  import scdma_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic              mem_ext,
  input wire logic [22:0]       mem_addr,
  input wire logic [15:0]       mem_wdata,
  input wire logic [15:0]       mem_rdata,
  input wire logic              mem_ack,
  input wire logic              cpu_gnt,
  input wire logic [NUM_CH-1:0] chan_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic acc;
  assign acc = hsel && hready && htrans == HTRANS_NSEQ && hsize == HSIZE_WORD;
  AST_RESP_OKAY: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  AST_RD_WAIT: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped early");
  AST_WR_DATA: assert property (mem_req && !mem_we && mem_ack |=>
    mem_req && mem_we && mem_wdata == $past(mem_rdata))
    else $error("write does not carry read word");
  AST_EXT_SINGLE: assert property (mem_req && mem_we && mem_ext && mem_ack
    |=> !mem_req)
    else $error("external access not single word");
  AST_CPU_YIELD: assert property (cpu_gnt |-> !mem_req)
    else $error("cpu granted during transfer");
  AST_IRQ_ONE: assert property (|chan_irq |-> $onehot(chan_irq) ##1
    chan_irq == '0)
    else $error("interrupt pulse wrong");
  // Main scenarios reached
  cover property (mem_req && mem_ext && mem_ack);
  cover property (|chan_irq);
  cover property (cpu_gnt);
endmodule : scdma_sva
bind scdma_top scdma_sva scdma_sva_i (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout,
  .hresp, .mem_req, .mem_we, .mem_ext, .mem_addr, .mem_wdata, .mem_rdata,
  .mem_ack, .cpu_gnt, .chan_irq
);
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scdma_pkg::*;
  logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic               cpu_req, cpu_gnt, mem_req, mem_we, mem_ext, mem_ack;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [22:0]        mem_addr;
  logic [15:0]        mem_wdata, mem_rdata;
  logic [NUM_EVT-1:0] sync_evt;
  logic [NUM_CH-1:0]  chan_irq;
  logic [3:0]         lat;
  int                 fail_count, total_checks;
  int                 irq_n [NUM_CH];

  scdma_top scdma_top_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_we,
    .mem_ext, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .sync_evt,
    .cpu_req, .cpu_gnt, .chan_irq
  );
  scdma_mem scdma_mem_i (
    .hclk, .hresetn, .mem_req, .mem_we, .mem_ext, .mem_addr, .mem_wdata,
    .lat, .mem_rdata, .mem_ack
  );

  // =========================================
  // Helpers
  always @(posedge hclk)
    for (int c = 0; c < NUM_CH; c++)
      if (chan_irq[c] === 1'b1)
        irq_n[c]++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] i,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, i, 2'b00};
    hwrite <= wr;
    htrans <= HTRANS_NSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, i, {16'h0, d}, x);
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [15:0] e);
    logic [31:0] x;
    bus(1'b0, i, 32'h0, x);
    chk(x, {16'h0, e});
  endtask : rdc

  task automatic chan(input logic [2:0] c, input logic [15:0] s, d, n, m);
    wr({CH_AREA, c, SLOT_SRC}, s);
    wr({CH_AREA, c, SLOT_DST}, d);
    wr({CH_AREA, c, SLOT_ECNT}, n);
    wr({CH_AREA, c, SLOT_MODE}, m);
  endtask : chan

  task automatic clr;
    repeat (10) @(posedge hclk);
    scdma_mem_i.wa.delete();
    scdma_mem_i.wd.delete();
    scdma_mem_i.wx.delete();
    scdma_mem_i.rx.delete();
  endtask : clr

  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (scdma_mem_i.wa.size() < n && k < 400)
    begin
      @(posedge hclk);
      k++;
    end
  endtask : wait_wr

  task automatic chk_wr(input int i, input logic [15:0] a, d,
                        input logic x);
    chk({9'h0, scdma_mem_i.wa[i]}, {16'h6, a});
    chk({16'h0, scdma_mem_i.wd[i]}, {16'h0, d});
    chk({31'h0, scdma_mem_i.wx[i]}, {31'h0, x});
  endtask : chk_wr

  // =========================================
  // Scenarios
  task automatic t_regs;
    rdc(IDX_EXTSEL, EXTSEL_RST);
    rdc(IDX_SRC_PAGE, 16'h0);
    wr(IDX_SRC_PAGE, 16'hffff);
    rdc(IDX_SRC_PAGE, 16'h007f);
    wr(8'h3f, 16'hffff);
    rdc(8'h3f, 16'h0);
    wr(IDX_SRC_PAGE, 16'h0005);
    wr(IDX_DST_PAGE, 16'h0006);
    rdc(IDX_DST_PAGE, 16'h0006);
    $display("test regs done");
  endtask : t_regs

  task automatic t_basic;
    cpu_req <= 1'b1;
    lat     <= 4'h2;
    chan(3'd0, 16'h0100, 16'h0200, 16'h0001, 16'h9108);
    wait_wr(2);
    repeat (8) @(posedge hclk);
    chk_wr(0, 16'h0200, 16'h5b00, 1'b0);
    chk_wr(1, 16'h01ff, 16'h5b01, 1'b0);
    chk(32'(irq_n[0]), 32'h1);
    chk({31'h0, cpu_gnt}, 32'h1);
    rdc({CH_AREA, 3'd0, SLOT_MODE}, 16'h1108);
    cpu_req <= 1'b0;
    $display("test basic done");
  endtask : t_basic

  task automatic t_ext;
    clr;
    lat <= 4'h0;
    chan(3'd2, 16'h0100, 16'h0300, 16'h0, 16'h8800);
    repeat (30) @(posedge hclk);
    chk(32'(scdma_mem_i.rx.size()), 32'h0);
    wr({CH_AREA, 3'd2, SLOT_MODE}, 16'h0);
    chan(3'd0, 16'h0100, 16'h0300, 16'h0, 16'h8800);
    wait_wr(1);
    chk_wr(0, 16'h0300, 16'h5b00, 1'b0);
    chk({31'h0, scdma_mem_i.rx[0]}, 32'h1);
    chan(3'd1, 16'h0400, 16'h0500, 16'h0, 16'h8020);
    wait_wr(2);
    chk_wr(1, 16'h0500, 16'h5e00, 1'b1);
    chan(3'd1, 16'h0010, 16'h0600, 16'h0, 16'h8020);
    repeat (30) @(posedge hclk);
    chk(32'(scdma_mem_i.wa.size()), 32'h2);
    wr({CH_AREA, 3'd1, SLOT_MODE}, 16'h0);
    clr;
    wr(IDX_EIDX, 16'h0002);
    chan(3'd0, 16'h0100, 16'h0200, 16'h0, 16'h810d);
    wait_wr(2);
    chk_wr(0, 16'h0200, 16'h5b00, 1'b0);
    chk_wr(1, 16'h0202, 16'h5b01, 1'b0);
    $display("test ext done");
  endtask : t_ext

  task automatic t_auto;
    clr;
    lat <= 4'h1;
    wr(IDX_GSRC, 16'h0700);
    wr(IDX_GDST, 16'h0800);
    chan(3'd3, 16'h0600, 16'h0900, 16'h0, 16'h9002);
    wait_wr(1);
    wr(IDX_GSRC, 16'h0740);
    wait_wr(3);
    wr({CH_AREA, 3'd3, SLOT_MODE}, 16'h0);
    chk_wr(0, 16'h0900, 16'h5c00, 1'b0);
    chk_wr(1, 16'h0800, 16'h5d00, 1'b0);
    chk_wr(2, 16'h0800, 16'h5d40, 1'b0);
    $display("test auto done");
  endtask : t_auto

  task automatic t_prio;
    clr;
    wr(IDX_PRIO, 16'h0010);
    wr({CH_AREA, 3'd4, SLOT_SYNC}, 16'h1);
    wr({CH_AREA, 3'd5, SLOT_SYNC}, 16'h1);
    chan(3'd5, 16'h0c00, 16'h0d00, 16'h0, 16'h8000);
    chan(3'd4, 16'h0a00, 16'h0b00, 16'h0, 16'h8000);
    repeat (20) @(posedge hclk);
    chk(32'(scdma_mem_i.wa.size()), 32'h0);
    sync_evt <= 16'h0002;
    @(posedge hclk);
    sync_evt <= 16'h0;
    wait_wr(2);
    chk_wr(0, 16'h0b00, 16'h5000, 1'b0);
    chk_wr(1, 16'h0d00, 16'h5600, 1'b0);
    $display("test prio done");
  endtask : t_prio

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // =========================================
  // Run
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    finish_test;
  end

  initial
  begin
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = HSIZE_WORD;
    hwdata   = 32'h0;
    cpu_req  = 1'b0;
    sync_evt = 16'h0;
    lat      = 4'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_basic;
    t_ext;
    t_auto;
    t_prio;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
